// File: bench/frame_sink_model.sv
// Purpose: frame builder side, takes filler octets
// Assumes: out_ready moves just after falling mclk
// Notes: slow mode takes one octet in three
`timescale 1ns/1ps
module frame_sink_model (
    input wire logic mclk, // clock
    input wire logic slow, // stall mode
    output logic out_ready // takes octet
);
    logic [1:0] ph_q = 2'h0;
    logic rdy_q = 1'b1;
    assign out_ready = rdy_q;
    // stall two cycles of three when slow
    always @(negedge mclk) begin
        ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
        rdy_q <= !slow || (ph_q == 2'h0);
    end
endmodule : frame_sink_model

// File: bench/idle_gen_chk.sv
// Purpose: stream checks on the filler generator ports
// Assumes: one clock, rst synchronous
// Notes: idx_q counts octets taken within a packet
`timescale 1ns/1ps
module idle_gen_chk (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic req, // request
    input wire logic [15:0] req_len_m1, // length
    input wire logic req_ready, // idle
    input wire logic [7:0] out_octet, // octet
    input wire logic out_last, // last
    input wire logic out_valid, // valid
    input wire logic out_ready, // ready
    input wire logic [13:0] seq_count // count
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [16:0] idx_q;
    logic [16:0] idx_d;
    // octet index inside the current packet
    always_comb begin
        idx_d = idx_q;
        if (out_valid && out_ready) idx_d = out_last ? 17'h0 : idx_q + 17'h1;
    end
    always_ff @(posedge mclk) idx_q <= rst ? 17'h0 : idx_d;
    sequence s_take; req && req_ready; endsequence
    sequence s_out; ##[1:4] out_valid; endsequence
    property p_reset;
        disable iff (1'b0) rst |=> !out_valid && !req_ready && seq_count == 14'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset");
    property p_take; s_take |=> !req_ready; endproperty
    a_take: assert property (p_take) else $error("busy missing");
    property p_start; s_take |-> s_out; endproperty
    a_start: assert property (p_start) else $error("no output");
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_octet) && $stable(out_last);
    endproperty
    a_hold: assert property (p_hold) else $error("octet dropped");
    property p_hdr0; out_valid && idx_q == 17'h0 |-> out_octet == 8'h07; endproperty
    a_hdr0: assert property (p_hdr0) else $error("bad octet 0");
    property p_hdr1; out_valid && idx_q == 17'h1 |-> out_octet == 8'hff; endproperty
    a_hdr1: assert property (p_hdr1) else $error("bad octet 1");
    property p_last; out_valid && out_last |-> idx_q >= 17'h6; endproperty
    a_last: assert property (p_last) else $error("short packet");
    property p_seq;
        seq_count != $past(seq_count) |-> seq_count == 14'($past(seq_count) + 14'h1)
            || seq_count == 14'h0;
    endproperty
    a_seq: assert property (p_seq) else $error("count jump");
endmodule : idle_gen_chk
bind idle_packet_generator idle_gen_chk u_chk (.mclk(mclk), .rst(rst), .req(req),
    .req_len_m1(req_len_m1), .req_ready(req_ready), .out_octet(out_octet),
    .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready), .seq_count(seq_count));

// File: bench/tb_top.sv
// Purpose: self-checking bench for the filler generator
// Assumes: inputs move on falling mclk
// Notes: count wrap is left to the checker
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic slow = 1'b0;
    logic [15:0] req_len_m1 = 16'h0;
    logic req_ready, out_last, out_valid, out_ready;
    logic [7:0] out_octet;
    logic [13:0] seq_count;
    logic [13:0] exp_seq = 14'h0;
    logic [7:0] pkt[$];
    int num_errors = 0;
    int total_checks = 0;
    initial forever #20 mclk = ~mclk;
    idle_packet_generator u_dut (.mclk(mclk), .rst(rst), .req(req), .req_len_m1(req_len_m1),
        .req_ready(req_ready), .out_octet(out_octet), .out_last(out_last),
        .out_valid(out_valid), .out_ready(out_ready), .seq_count(seq_count));
    frame_sink_model u_sink (.mclk(mclk), .slow(slow), .out_ready(out_ready));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic print_verdict;
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // ask for one packet, hold until taken
    task automatic send(input logic [15:0] len);
        logic taken;
        taken = 1'b0;
        @(negedge mclk);
        req = 1'b1;
        req_len_m1 = len;
        repeat (300) begin
            @(posedge mclk);
            if (req_ready === 1'b1) begin
                taken = 1'b1;
                break;
            end
        end
        // a request that is never taken counts against the run
        chk("req_taken", taken, 1'b1);
        @(negedge mclk);
        req = 1'b0;
    endtask : send
    // gather and judge one packet
    task automatic take(input logic [15:0] len);
        logic diff;
        diff = 1'b0;
        pkt.delete();
        repeat (3000) begin
            @(posedge mclk);
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                pkt.push_back(out_octet);
                if (out_last === 1'b1) break;
            end
        end
        chk("size", pkt.size(), len + 7);
        chk("hdr0", pkt[0], 8'h07);
        chk("hdr1", pkt[1], 8'hff);
        chk("hdr2", pkt[2], {2'h3, exp_seq[13:8]});
        chk("hdr3", pkt[3], exp_seq[7:0]);
        chk("len", {pkt[4], pkt[5]}, len);
        foreach (pkt[i]) if (i > 6 && pkt[i] !== pkt[6]) diff = 1'b1;
        if (len > 0) chk("random", diff, 1'b1);
        exp_seq++;
    endtask : take
    // two packets back to back
    task automatic t_back;
        fork
            begin send(16'h0); send(16'h1); end
            begin take(16'h0); take(16'h1); end
        join
    endtask : t_back
    // long packet piles up in the fifo under stalls
    task automatic t_stall;
        slow = 1'b1;
        fork
            send(16'h27);
            take(16'h27);
        join
        slow = 1'b0;
    endtask : t_stall
    // request during a packet is ignored
    task automatic t_refuse;
        fork
            begin
                send(16'h3);
                @(negedge mclk);
                req = 1'b1;
                repeat (3) @(negedge mclk);
                req = 1'b0;
            end
            take(16'h3);
        join
        repeat (20) @(negedge mclk);
        chk("extra", out_valid, 1'b0);
        chk("seq", seq_count, exp_seq);
    endtask : t_refuse
    initial begin
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        chk("seq0", seq_count, 14'h0);
        t_back();
        t_stall();
        t_refuse();
        print_verdict();
    end
    initial begin
        #400000;
        num_errors++;
        print_verdict();
    end
endmodule : tb_top

// File: inc/idle_pkt_pkg.sv
// Purpose: constants shared by the filler packet generator and its fifo
// Assumes: octet-wide output stream, one system clock
// Notes: header layout is fixed; only the data field length varies
package idle_pkt_pkg;
    localparam logic [2:0] version_val = 3'h0;
    localparam logic type_val = 1'h0;
    localparam logic sec_hdr_flag_val = 1'h0;
    localparam logic [10:0] apid_idle_val = 11'h7ff;
    localparam logic [1:0] seg_flags_val = 2'h3;
    localparam int seq_width = 14;
    localparam logic [13:0] seq_reset_val = 14'h0000;
    localparam int hdr_octets = 6;
    localparam int hdr_bits = 48;
    localparam logic [2:0] hdr_last_idx = 3'h5;
    localparam int fifo_width = 9;
    localparam int fifo_depth = 32;
    localparam logic [31:0] lfsr_seed = 32'h1234abcd;
    localparam logic [31:0] lfsr_taps = 32'h80200003;
    typedef enum logic [1:0] {st_idle, st_header, st_data} gen_state_t;
endpackage : idle_pkt_pkg

// File: verilog/idle_packet_generator.sv
// Purpose: builds filler packets (6-octet header plus random data field)
// Assumes: requester gives a length and holds its request until req_ready is high when filler is needed
// Notes: octets pass through a 32-word fifo; consumer can stall the stream
`timescale 1ns/1ps
module idle_packet_generator
    import idle_pkt_pkg::*;
(
    input wire logic mclk, // 25 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic req, // request one filler packet
    input wire logic [15:0] req_len_m1, // data field octets minus one
    output logic req_ready, // generator can accept a request
    output logic [7:0] out_octet, // stream octet
    output logic out_last, // last octet of a packet
    output logic out_valid, // stream octet valid
    input wire logic out_ready, // consumer accepts octet
    output logic [13:0] seq_count // count for the next packet
);
    gen_state_t state_q, state_d;
    logic [13:0] seq_q, seq_d;
    logic [15:0] len_q, len_d;
    logic [15:0] left_q, left_d;
    logic [2:0] hidx_q, hidx_d;
    logic [47:0] hdr_q, hdr_d;
    logic [31:0] lfsr_q, lfsr_d;
    logic [8:0] f_in;
    logic f_valid;
    logic f_ready;
    logic [8:0] f_out;
    logic f_out_valid;
    logic f_pop;
    logic [7:0] oct_q, oct_d;
    logic last_q, last_d;
    logic ov_q, ov_d;
    logic rdy_q, rdy_d;

    // assembles the 48-bit header, fields in wire order
    function automatic logic [47:0] build_hdr(input logic [13:0] seq, input logic [15:0] len);
        build_hdr = {version_val,
            type_val,
            sec_hdr_flag_val,
            apid_idle_val,
            seg_flags_val,
            seq,
            len};
    endfunction : build_hdr

    // next-state logic of the packet sequencer
    always_comb begin
        state_d = state_q;
        seq_d = seq_q;
        len_d = len_q;
        left_d = left_q;
        hidx_d = hidx_q;
        hdr_d = hdr_q;
        f_in = 9'h000;
        f_valid = 1'b0;
        // lfsr runs free so data octets are unrelated to each other
        lfsr_d = lfsr_q[0] ? ((lfsr_q >> 1) ^ lfsr_taps) : (lfsr_q >> 1);
        case (state_q)
            st_idle: begin
                if (req) begin
                    len_d = req_len_m1;
                    hdr_d = build_hdr(seq_q, req_len_m1);
                    hidx_d = 3'h0;
                    state_d = st_header;
                end
            end
            st_header: begin
                f_in = {1'b0, hdr_q[47:40]};
                f_valid = 1'b1;
                if (f_ready) begin
                    hdr_d = {hdr_q[39:0], 8'h00};
                    hidx_d = hidx_q + 3'h1;
                    if (hidx_q == hdr_last_idx) begin
                        left_d = len_q;
                        state_d = st_data;
                    end
                end
            end
            st_data: begin
                f_in = {(left_q == 16'h0000), lfsr_q[7:0]};
                f_valid = 1'b1;
                if (f_ready) begin
                    left_d = left_q - 16'h0001;
                    if (left_q == 16'h0000) begin
                        // packet released: count steps, wrapping at 2^14-1
                        seq_d = seq_q + 14'h0001;
                        state_d = st_idle;
                    end
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= st_idle;
            seq_q <= seq_reset_val;
            len_q <= 16'h0000;
            left_q <= 16'h0000;
            hidx_q <= 3'h0;
            hdr_q <= 48'h000000000000;
            lfsr_q <= lfsr_seed;
        end else begin
            state_q <= state_d;
            seq_q <= seq_d;
            len_q <= len_d;
            left_q <= left_d;
            hidx_q <= hidx_d;
            hdr_q <= hdr_d;
            lfsr_q <= lfsr_d;
        end
    end

    // octet buffer between sequencer and consumer
    octet_fifo #(
        .width(fifo_width),
        .depth(fifo_depth)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_data(f_in),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .out_data(f_out),
        .out_valid(f_out_valid),
        .out_ready(f_pop)
    );

    // registered output stage, a skid-free single register slice
    always_comb begin
        f_pop = f_out_valid && (!ov_q || out_ready);
        oct_d = oct_q;
        last_d = last_q;
        ov_d = ov_q;
        if (!ov_q || out_ready) begin
            ov_d = f_out_valid;
            if (f_out_valid) begin
                oct_d = f_out[7:0];
                last_d = f_out[8];
            end
        end
        rdy_d = (state_d == st_idle);
    end

    // output registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            oct_q <= 8'h00;
            last_q <= 1'b0;
            ov_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            oct_q <= oct_d;
            last_q <= last_d;
            ov_q <= ov_d;
            rdy_q <= rdy_d;
        end
    end

    assign out_octet = oct_q;
    assign out_last = last_q;
    assign out_valid = ov_q;
    assign req_ready = rdy_q;
    assign seq_count = seq_q;
endmodule : idle_packet_generator

// File: verilog/octet_fifo.sv
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: width and depth are parameters; depth must be a power of two
`timescale 1ns/1ps
module octet_fifo #(
    parameter int width = 9,
    parameter int depth = 32
) (
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic [width-1:0] in_data, // write word
    input wire logic in_valid, // write request
    output logic in_ready, // not full
    output logic [width-1:0] out_data, // head word
    output logic out_valid, // not empty
    input wire logic out_ready // reader takes head
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [aw:0] cnt_q, cnt_d;
    logic push, pop;

    // handshake terms and pointer/count updates
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // register pointers and storage
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // honest full and empty flags
    assign in_ready = (cnt_q != depth[aw:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
endmodule : octet_fifo
